/* src/ccr_regs.sv */
`timescale 1ns/1ps
`include "ccr_params.svh"

module ccr_regs #(
    parameter logic [7:0] REG07_RESET = 8'h00
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             scl,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe,
    input  wire logic             source_select_pin,
    input  wire logic             host_supply_pin,
    input  wire logic [2:0]       external_current_cap_pin,
    input  wire ccr_pkg::ccr_byte_t status_08,
    input  wire ccr_pkg::ccr_byte_t status_09,
    input  wire ccr_pkg::ccr_byte_t status_0a,
    output logic                  high_impedance_enable,
    output logic [3:0]            input_voltage_floor,
    output logic [2:0]            input_current_cap,
    output logic                  boost_output_enable,
    output logic                  charge_enable_bit,
    output logic                  charge_active,
    output logic [2:0]            system_voltage_floor,
    output logic                  boost_current_cap,
    output logic [5:0]            fast_charge_current,
    output logic [12:0]           fast_charge_ma,
    output logic                  cold_threshold_select,
    output logic                  reduced_charge_force,
    output logic                  precharge_halve,
    output logic                  watchdog_restart,
    output logic [7:0]            watchdog_seconds,
    output ccr_pkg::ccr_byte_t    ext_reg_03,
    output ccr_pkg::ccr_byte_t    ext_reg_04,
    output ccr_pkg::ccr_byte_t    ext_reg_05,
    output ccr_pkg::ccr_byte_t    ext_reg_06,
    output ccr_pkg::ccr_byte_t    ext_reg_07
);
    import ccr_pkg::*;

    ccr_state_t state_r;
    logic       scl_r;
    logic       sda_r;
    logic [7:0] sh_r;
    logic [3:0] cnt_r;
    logic       rw_r;
    logic [7:0] ptr_r;
    logic [7:0] in_r;
    logic [5:0] pwr_r;
    logic [7:0] chg_r;
    logic [7:0] ext_r [3:7];
    logic [2:0] cap_def;
    logic [7:0] rd_byte;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       byte_done;
    logic       wr_fire;
    logic       reg_reset;
    logic [12:0] fast_full;

    assign sda_o     = 1'b0;
    assign scl_rise  = scl & ~scl_r;
    assign scl_fall  = ~scl & scl_r;
    assign bus_start = scl & scl_r & sda_r & ~sda_i;
    assign bus_stop  = scl & scl_r & ~sda_r & sda_i;
    assign byte_done = scl_fall && (cnt_r == `CCR_BITS_PER_BYTE);
    assign wr_fire   = (state_r == ST_WDATA) && byte_done;
    assign reg_reset = wr_fire && (ptr_r == `CCR_IDX_POWER)
                       && sh_r[`CCR_PWR_RST_BIT];

    always_comb begin
        if (source_select_pin) begin
            cap_def = host_supply_pin ? `CCR_CAP_500MA : `CCR_CAP_100MA;
        end else begin
            cap_def = `CCR_CAP_3A;
        end
    end

    // Action bits are not stored, so they always read back as zero.
    always_comb begin
        rd_byte = 8'h00;
        if (ptr_r == `CCR_IDX_INPUT) begin
            rd_byte = in_r;
        end else if (ptr_r == `CCR_IDX_POWER) begin
            rd_byte = {2'b00, pwr_r};
        end else if (ptr_r == `CCR_IDX_CHARGE) begin
            rd_byte = chg_r;
        end else if (ptr_r <= `CCR_IDX_RW_HI) begin
            rd_byte = ext_r[ptr_r[2:0]];
        end else if (ptr_r == `CCR_IDX_RO_LO) begin
            rd_byte = status_08;
        end else if (ptr_r == `CCR_IDX_RO_LO + 8'h01) begin
            rd_byte = status_09;
        end else if (ptr_r == `CCR_IDX_RO_HI) begin
            rd_byte = status_0a;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            scl_r <= scl;
            sda_r <= sda_i;
        end
    end

    // Serial engine: sample on rising SCL, drive SDA after falling SCL.
    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= ST_IDLE;
            sh_r    <= 8'h00;
            cnt_r   <= 4'h0;
            rw_r    <= 1'b0;
            ptr_r   <= 8'h00;
            sda_oe  <= 1'b0;
        end else if (bus_start) begin
            state_r <= ST_ADDR;
            cnt_r   <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (bus_stop) begin
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else begin
            case (state_r)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        sh_r  <= {sh_r[6:0], sda_i};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (byte_done) begin
                        sda_oe <= 1'b1;
                        if (state_r == ST_ADDR) begin
                            if (sh_r[7:1] == `CCR_BUS_ADDR) begin
                                rw_r    <= sh_r[0];
                                state_r <= ST_ADDR_ACK;
                            end else begin
                                sda_oe  <= 1'b0;
                                state_r <= ST_IDLE;
                            end
                        end else if (state_r == ST_PTR) begin
                            ptr_r   <= sh_r;
                            state_r <= ST_PTR_ACK;
                        end else begin
                            ptr_r   <= ptr_r + 8'h01;
                            state_r <= ST_WDATA_ACK;
                        end
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_oe  <= 1'b0;
                        cnt_r   <= 4'h0;
                        state_r <= ST_WDATA;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= 4'h1;
                        if (rw_r) begin
                            sda_oe  <= ~rd_byte[7];
                            sh_r    <= {rd_byte[6:0], 1'b0};
                            state_r <= ST_RDATA;
                        end else begin
                            sda_oe  <= 1'b0;
                            cnt_r   <= 4'h0;
                            state_r <= ST_PTR;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_r == `CCR_BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            ptr_r  <= ptr_r + 8'h01;
                            cnt_r  <= cnt_r + 4'h1;
                        end else if (cnt_r > `CCR_BITS_PER_BYTE) begin
                            sda_oe <= ~rd_byte[7];
                            sh_r   <= {rd_byte[6:0], 1'b0};
                            cnt_r  <= 4'h1;
                        end else begin
                            sda_oe <= ~sh_r[7];
                            sh_r   <= {sh_r[6:0], 1'b0};
                            cnt_r  <= cnt_r + 4'h1;
                        end
                    end else if (scl_rise && cnt_r > `CCR_BITS_PER_BYTE
                                 && sda_i) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst || reg_reset) begin
            in_r  <= {1'b0, `CCR_IN_VFLOOR_DEF, cap_def};
            pwr_r <= `CCR_PWR_DEF;
            chg_r <= `CCR_CHG_DEF;
        end else if (wr_fire) begin
            if (ptr_r == `CCR_IDX_INPUT) begin
                in_r <= sh_r;
            end else if (ptr_r == `CCR_IDX_POWER) begin
                pwr_r <= sh_r[5:0];
            end else if (ptr_r == `CCR_IDX_CHARGE) begin
                chg_r <= sh_r;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 3; gi <= 7; gi++) begin : g_ext
            localparam logic [7:0] DEF =
                (gi == 3) ? `CCR_REG03_DEF : (gi == 4) ? `CCR_REG04_DEF :
                (gi == 5) ? `CCR_REG05_DEF : (gi == 6) ? `CCR_REG06_DEF :
                REG07_RESET;
            always_ff @(posedge clock) begin
                if (srst || reg_reset) begin
                    ext_r[gi] <= DEF;
                end else if (wr_fire && ptr_r == 8'(gi)) begin
                    ext_r[gi] <= sh_r;
                end
            end
        end
    endgenerate

    assign fast_full = `CCR_FAST_OFFS_MA
                       + (13'(chg_r[7:2]) << `CCR_FAST_STEP_SH);

    always_ff @(posedge clock) begin
        if (srst) begin
            input_current_cap <= `CCR_CAP_100MA;
            charge_active     <= 1'b0;
            fast_charge_ma    <= 13'h0000;
            watchdog_seconds  <= `CCR_WDG_OFF;
            watchdog_restart  <= 1'b0;
        end else begin
            input_current_cap <= (in_r[2:0] < external_current_cap_pin)
                                 ? in_r[2:0] : external_current_cap_pin;
            charge_active     <= pwr_r[4] & ~pwr_r[5];
            fast_charge_ma    <= chg_r[0] ? fast_full / `CCR_FAST_DIV
                                          : fast_full;
            watchdog_restart  <= wr_fire && (ptr_r == `CCR_IDX_POWER)
                                 && sh_r[`CCR_PWR_WDG_BIT];
            case (ext_r[5][5:4])
                2'b00:   watchdog_seconds <= `CCR_WDG_OFF;
                2'b01:   watchdog_seconds <= `CCR_WDG_40S;
                2'b10:   watchdog_seconds <= `CCR_WDG_80S;
                default: watchdog_seconds <= `CCR_WDG_160S;
            endcase
        end
    end

    assign high_impedance_enable = in_r[`CCR_IN_HIZ_BIT];
    assign input_voltage_floor   = in_r[6:3];
    assign boost_output_enable   = pwr_r[5];
    assign charge_enable_bit     = pwr_r[4];
    assign system_voltage_floor  = pwr_r[3:1];
    assign boost_current_cap     = pwr_r[0];
    assign fast_charge_current   = chg_r[7:2];
    assign cold_threshold_select = chg_r[1];
    assign reduced_charge_force  = chg_r[0];
    assign precharge_halve       = chg_r[0];
    assign ext_reg_03            = ext_r[3];
    assign ext_reg_04            = ext_r[4];
    assign ext_reg_05            = ext_r[5];
    assign ext_reg_06            = ext_r[6];
    assign ext_reg_07            = ext_r[7];

    property p_addr_ack;
        @(posedge clock) disable iff (srst)
        (state_r == ST_ADDR && byte_done && !bus_start && !bus_stop)
        |=> (sda_oe == ($past(sh_r[7:1]) == `CCR_BUS_ADDR));
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("bad address ack");

    property p_ro_stable;
        @(posedge clock) disable iff (srst)
        (wr_fire && ptr_r > `CCR_IDX_RW_HI)
        |=> ($stable(in_r) && $stable(pwr_r) && $stable(chg_r));
    endproperty
    a_ro_stable: assert property (p_ro_stable) else $error("ro write hit");

    property p_hiz_write;
        @(posedge clock) disable iff (srst)
        (wr_fire && ptr_r == `CCR_IDX_INPUT)
        |=> (high_impedance_enable == $past(sh_r[7]))
            && (input_voltage_floor == $past(sh_r[6:3]));
    endproperty
    a_hiz_write: assert property (p_hiz_write) else $error("input reg");

    property p_cap_min;
        @(posedge clock) disable iff (srst)
        ##1 (input_current_cap <= $past(in_r[2:0]))
            && (input_current_cap <= $past(external_current_cap_pin));
    endproperty
    a_cap_min: assert property (p_cap_min) else $error("cap not min");

    property p_cap_default;
        @(posedge clock)
        srst |=> (in_r[2:0] == ($past(source_select_pin)
            ? ($past(host_supply_pin) ? `CCR_CAP_500MA : `CCR_CAP_100MA)
            : `CCR_CAP_3A));
    endproperty
    a_cap_default: assert property (p_cap_default) else $error("cap def");

    property p_reg_reset;
        @(posedge clock) disable iff (srst)
        reg_reset |=> (pwr_r == `CCR_PWR_DEF) && (chg_r == `CCR_CHG_DEF)
                      && (ext_r[5] == `CCR_REG05_DEF);
    endproperty
    a_reg_reset: assert property (p_reg_reset) else $error("no reset");

    property p_wdg_pulse;
        @(posedge clock) disable iff (srst)
        (wr_fire && ptr_r == `CCR_IDX_POWER && sh_r[`CCR_PWR_WDG_BIT])
        |=> watchdog_restart ##1 !watchdog_restart;
    endproperty
    a_wdg_pulse: assert property (p_wdg_pulse) else $error("wdg pulse");

    property p_boost_override;
        @(posedge clock) disable iff (srst)
        boost_output_enable [*2] |-> !charge_active;
    endproperty
    a_boost_override: assert property (p_boost_override) else $error("boost");

    property p_force_fifth;
        @(posedge clock) disable iff (srst)
        (reduced_charge_force && $stable(chg_r)) |=>
            (fast_charge_ma == $past(fast_full) / `CCR_FAST_DIV);
    endproperty
    a_force_fifth: assert property (p_force_fifth) else $error("force");

    property p_action_read;
        @(posedge clock) disable iff (srst)
        (ptr_r == `CCR_IDX_POWER) |-> (rd_byte[7:6] == 2'b00);
    endproperty
    a_action_read: assert property (p_action_read) else $error("action");

endmodule

/* src/ccr_params.svh */
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

`define CCR_BUS_ADDR      7'h6B
`define CCR_IDX_INPUT     8'h00
`define CCR_IDX_POWER     8'h01
`define CCR_IDX_CHARGE    8'h02
`define CCR_IDX_EXT_LO    8'h03
`define CCR_IDX_RW_HI     8'h07
`define CCR_IDX_RO_LO     8'h08
`define CCR_IDX_RO_HI     8'h0A
`define CCR_BITS_PER_BYTE 4'h8
`define CCR_IN_HIZ_BIT    7
`define CCR_IN_VFLOOR_DEF 4'h6
`define CCR_CAP_3A        3'h7
`define CCR_CAP_100MA     3'h0
`define CCR_CAP_500MA     3'h2
`define CCR_PWR_RST_BIT   7
`define CCR_PWR_WDG_BIT   6
`define CCR_PWR_DEF       6'h1B
`define CCR_CHG_DEF       8'h60
`define CCR_REG03_DEF     8'h11
`define CCR_REG04_DEF     8'hB2
`define CCR_REG05_DEF     8'h9A
`define CCR_REG06_DEF     8'h73
`define CCR_WDG_IDX       2
`define CCR_WDG_OFF       8'h00
`define CCR_WDG_40S       8'h28
`define CCR_WDG_80S       8'h50
`define CCR_WDG_160S      8'hA0
`define CCR_FAST_OFFS_MA  13'h0200
`define CCR_FAST_STEP_SH  6
`define CCR_FAST_DIV      13'h0005

`endif

/* src/ccr_pkg.sv */
package ccr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA
    } ccr_state_t;

    typedef logic [7:0] ccr_byte_t;

endpackage

/* verif/ccr_host.sv */
`timescale 1ns/1ps

module ccr_host (
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Each phase lasts four clocks; scl is high for one phase and low for two, longer than the slave's minimum.
    task automatic phase();
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic start_cond();
        sda_pull = 1'b0;
        phase();
        scl = 1'b1;
        phase();
        sda_pull = 1'b1;
        phase();
        scl = 1'b0;
        phase();
    endtask

    task automatic stop_cond();
        sda_pull = 1'b1;
        phase();
        scl = 1'b1;
        phase();
        sda_pull = 1'b0;
        phase();
    endtask

    // Data changes only while scl is low and is sampled at the end of high.
    task automatic bit_io(input logic b, output logic seen);
        sda_pull = ~b;
        phase();
        scl = 1'b1;
        phase();
        seen = sda;
        scl = 1'b0;
        phase();
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(nack, s);
    endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps

module tb;
    import ccr_pkg::*;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        scl, sda_pull, sda_o, sda_oe, sel = 1'b0, host = 1'b0;
    logic [2:0]  pin = 3'h7;
    ccr_byte_t   st8 = 8'h00, st9 = 8'h00, sta = 8'h00;
    logic        hiz, boost, chg, act, bcap, cold, force20, halve, wdr;
    logic [3:0]  vfl;
    logic [2:0]  cap, sysv;
    logic [5:0]  fcc;
    logic [12:0] ma;
    logic [7:0]  wds, r00, r01, r02, v, w, ext [3:7];
    logic        ack;
    wire         sda = ~(sda_pull | sda_oe);
    integer      seed = 46;
    int          bad_count = 0, samples_checked = 0, wd_pulses = 0;

    always #4 clock = ~clock;
    always @(posedge clock) if (wdr === 1'b1) wd_pulses++;

    ccr_host host_u (.clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull));

    ccr_regs dut_u (.clock(clock), .srst(srst), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .source_select_pin(sel),
        .host_supply_pin(host), .external_current_cap_pin(pin),
        .status_08(st8), .status_09(st9), .status_0a(sta),
        .high_impedance_enable(hiz), .input_voltage_floor(vfl),
        .input_current_cap(cap), .boost_output_enable(boost),
        .charge_enable_bit(chg), .charge_active(act),
        .system_voltage_floor(sysv), .boost_current_cap(bcap),
        .fast_charge_current(fcc), .fast_charge_ma(ma),
        .cold_threshold_select(cold), .reduced_charge_force(force20),
        .precharge_halve(halve), .watchdog_restart(wdr),
        .watchdog_seconds(wds), .ext_reg_03(ext[3]), .ext_reg_04(ext[4]),
        .ext_reg_05(ext[5]), .ext_reg_06(ext[6]), .ext_reg_07(ext[7]));

    function automatic logic [2:0] cap_def(input logic s, input logic h);
        return s ? (h ? 3'h2 : 3'h0) : 3'h7;
    endfunction

    function automatic logic [12:0] fast_ma(input logic [7:0] r);
        logic [12:0] m;
        m = 13'h0200 + 13'(r[7:2]) * 13'h0040;
        return r[0] ? m / 13'h0005 : m;
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_out(input string n, input logic [15:0] e,
                           input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
        host_u.start_cond();
        host_u.send({7'h6B, 1'b0}, ack);
        chk_out("addr_ack", 16'h0001, 16'(ack));
        host_u.send(idx, ack);
        host_u.send(val, ack);
        host_u.stop_cond();
    endtask

    task automatic reg_rd(input logic [7:0] idx, output logic [7:0] val);
        host_u.start_cond();
        host_u.send({7'h6B, 1'b0}, ack);
        host_u.send(idx, ack);
        host_u.start_cond();
        host_u.send({7'h6B, 1'b1}, ack);
        host_u.recv(1'b1, val);
        host_u.stop_cond();
    endtask

    task automatic do_reset();
        @(posedge clock) #1 srst = 1'b1;
        repeat (6) @(posedge clock);
        #1 srst = 1'b0;
        r00 = {1'b0, 4'h6, cap_def(sel, host)};
        r01 = 8'h1B;
        r02 = 8'h60;
    endtask

    task automatic check_all();
        reg_rd(8'h00, v);
        chk_byte("input_source_control", r00, v);
        reg_rd(8'h01, v);
        chk_byte("power_on_configuration", r01 & 8'h3F, v);
        reg_rd(8'h02, v);
        chk_byte("charge_current_control", r02, v);
        chk_out("hiz", 16'(r00[7]), 16'(hiz));
        chk_out("vfloor", 16'(r00[6:3]), 16'(vfl));
        chk_out("cap", 16'(r00[2:0] < pin ? r00[2:0] : pin), 16'(cap));
        chk_out("boost", 16'(r01[5]), 16'(boost));
        chk_out("chg", 16'(r01[4]), 16'(chg));
        chk_out("active", 16'(r01[4] & ~r01[5]), 16'(act));
        chk_out("sysv", 16'(r01[3:1]), 16'(sysv));
        chk_out("bcap", 16'(r01[0]), 16'(bcap));
        chk_out("fcc", 16'(r02[7:2]), 16'(fcc));
        chk_out("ma", 16'(fast_ma(r02)), 16'(ma));
        chk_out("cold", 16'(r02[1]), 16'(cold));
        chk_out("force", 16'(r02[0]), 16'(force20));
        chk_out("halve", 16'(r02[0]), 16'(halve));
    endtask

    initial begin
        repeat (90000) @(posedge clock);
        bad_count++;
        close_out();
    end

    initial begin
        for (int k = 0; k < 4; k++) begin
            {sel, host} = 2'(k);
            do_reset();
            check_all();
        end
        $display("test defaults done");
        for (int i = 0; i < 10; i++) begin
            pin = 3'($random(seed));
            r00 = 8'($random(seed));
            r01 = 8'($random(seed)) & 8'h3F;
            // Codes stay within 0..39; above that the part is unsupported.
            r02 = {6'({$random(seed)} % 40), 2'($random(seed))};
            if (i == 0) r02 = {6'd39, 2'b11};
            reg_wr(8'h00, r00);
            reg_wr(8'h01, r01);
            reg_wr(8'h02, r02);
            check_all();
        end
        $display("test random fields done");
        for (int i = 3; i < 8; i++) begin
            w = 8'($random(seed));
            reg_wr(8'(i), w);
            reg_rd(8'(i), v);
            chk_byte("ext_rd", w, v);
            chk_byte("ext_out", w, ext[i]);
        end
        for (int c = 0; c < 4; c++) begin
            reg_wr(8'h05, {2'b10, 2'(c), 4'hA});
            chk_out("wdsec", 16'(c == 0 ? 0 : 20 << c), 16'(wds));
        end
        $display("test upper registers done");
        {st8, st9, sta} = 24'($random(seed));
        for (int i = 8; i < 11; i++) begin
            reg_wr(8'(i), 8'hA5);
            reg_rd(8'(i), v);
            chk_byte("ro", i == 8 ? st8 : (i == 9 ? st9 : sta), v);
        end
        reg_rd(8'h0B, v);
        chk_byte("unmapped", 8'h00, v);
        host_u.start_cond();
        host_u.send({7'h6A, 1'b0}, ack);
        host_u.stop_cond();
        chk_out("wrong_addr", 16'h0000, 16'(ack));
        $display("test read only done");
        wd_pulses = 0;
        reg_wr(8'h01, r01 | 8'h40);
        chk_out("wd_pulse", 16'h0001, 16'(wd_pulses));
        repeat (2600) @(posedge clock);
        reg_wr(8'h01, r01 | 8'h40);
        chk_out("wd_pulse2", 16'h0002, 16'(wd_pulses));
        check_all();
        $display("test watchdog restart done");
        host = 1'b0;
        reg_wr(8'h01, 8'hE0);
        r00 = {1'b0, 4'h6, cap_def(sel, host)};
        r01 = 8'h1B;
        r02 = 8'h60;
        check_all();
        chk_byte("ext03", 8'h11, ext[3]);
        chk_byte("ext06", 8'h73, ext[6]);
        $display("test register reset done");
        close_out();
    end
endmodule
